// ===== rtl/fault_mux_pkg.sv
// Purpose: constants and carriers for the fault routing block
// Assumes: word-addressed register port, 32-bit data
// Notes:   source vector layout and register offsets live here
package fault_mux_pkg;

  // engine and source counts
  localparam int unsigned N_ENG    = 4;
  localparam int unsigned N_MOD    = 4;
  localparam int unsigned N_DCOMP  = 4;
  localparam int unsigned N_ACOMP  = 7;
  localparam int unsigned N_EXT    = 4;
  localparam int unsigned N_EFLT   = 5;
  localparam int unsigned N_SRC    = 22;
  localparam int unsigned CNT_W    = 4;
  localparam int unsigned THR_W    = 12;
  localparam int unsigned ATHR_W   = 7;
  localparam int unsigned FAULT_IRQ_PRIO = 25;

  // fault module index inside an engine
  localparam int unsigned M_CBC = 0;
  localparam int unsigned M_AB  = 1;
  localparam int unsigned M_A   = 2;
  localparam int unsigned M_B   = 3;

  // source vector positions
  localparam int unsigned S_DCOMP = 0;
  localparam int unsigned S_ACOMP = 4;
  localparam int unsigned S_EXT   = 11;
  localparam int unsigned S_ENG   = 15;
  localparam int unsigned S_HF    = 19;
  localparam int unsigned S_LF    = 20;
  localparam int unsigned S_DCM   = 21;

  // register word addresses
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_EXT     = 8'h01;
  localparam logic [7:0] A_ENGCFG  = 8'h02;
  localparam logic [7:0] A_MISC    = 8'h03;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_SRC     = 8'h05;
  localparam logic [7:0] A_DCOMP   = 8'h08;
  localparam logic [7:0] A_ATHR    = 8'h10;
  localparam logic [7:0] A_MAXCNT  = 8'h18;
  localparam logic [7:0] A_MASK    = 8'h20;

  // field positions
  localparam int unsigned F_FEN     = 0;
  localparam int unsigned F_ENGEN   = 4;
  localparam int unsigned F_BMATCH  = 8;
  localparam int unsigned F_EXTPOL  = 4;
  localparam int unsigned F_HFEN    = 0;
  localparam int unsigned F_LFEN    = 1;
  localparam int unsigned F_DCMEN   = 2;
  localparam int unsigned F_ACEN    = 3;
  localparam int unsigned F_DCEN    = 16;

  // reset values
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [CNT_W-1:0] RST_CNT = 4'h0;

  // per-engine inputs from the pwm engine
  typedef struct packed {
    logic cyc_start;
    logic pwm_a;
    logic pwm_b;
    logic pcm;
    logic cur_lim;
    logic ov;
    logic ext_a;
    logic ext_b;
    logic diode_emulation_flag;
  } eng_in_s;

  // per-engine outputs
  typedef struct packed {
    logic pwm_a;
    logic pwm_b;
  } eng_out_s;

endpackage : fault_mux_pkg

// ===== rtl/pwm_fault_response_mux.sv
// Purpose: fault routing and per-engine fault response
// Assumes: cyc_start is a one-cycle pulse at each switching-cycle start
// Notes:   one register port, read data one cycle after read strobe
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module fault_cell
  import fault_mux_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // control
  input  wire logic             eng_en_i,
  input  wire logic             fault_en_i,
  input  wire logic             cyc_start_i,
  input  wire logic             fault_i,
  input  wire logic [CNT_W-1:0] max_cnt_i,
  // state
  output logic                  flag_o,
  output logic      [CNT_W-1:0] cnt_o
);
  logic             seen_q;
  logic             flag_q;
  logic [CNT_W-1:0] cnt_q;
  logic             det;
  logic             hit;
  logic [CNT_W:0]   cnt_inc;

  assign det     = fault_i & fault_en_i;
  assign hit     = seen_q | det;
  assign cnt_inc = {1'b0, cnt_q} + {{CNT_W{1'b0}}, 1'b1};

  // one detection per cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || !eng_en_i) begin
      seen_q <= 1'b0;
    end else if (cyc_start_i) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= hit;
    end
  end

  // consecutive count, cleared on a clean cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || !eng_en_i) begin
      cnt_q <= RST_CNT;
    end else if (cyc_start_i) begin
      if (!hit) begin
        cnt_q <= RST_CNT;
      end else if (!cnt_inc[CNT_W]) begin
        cnt_q <= cnt_inc[CNT_W-1:0];
      end
    end
  end

  // sticky flag
  always_ff @(posedge clk_i) begin
    if (rst_i || !eng_en_i) begin
      flag_q <= 1'b0;
    end else if (cyc_start_i && hit && (cnt_inc > {1'b0, max_cnt_i})) begin
      flag_q <= 1'b1;
    end
  end

  assign flag_o = flag_q;
  assign cnt_o  = cnt_q;
endmodule : fault_cell

module pwm_fault_response_mux
  import fault_mux_pkg::*;
#(
  parameter int unsigned NE = N_ENG
)
(
  // clock and reset
  input  wire logic                      CLK_SYS_I,
  input  wire logic                      SYS_RST_I,
  // register port
  input  wire logic [7:0]                ADDR_I,
  input  wire logic [31:0]               WDATA_I,
  input  wire logic                      WR_I,
  input  wire logic                      RD_I,
  output logic      [31:0]               RDATA_O,
  // fault sources
  input  wire logic [N_DCOMP*THR_W-1:0]  DCOMP_VAL_I,
  input  wire logic [N_ACOMP-1:0]        ACOMP_I,
  input  wire logic [N_EXT-1:0]          EXT_FAULT_I,
  input  wire logic                      HF_CLK_FAIL_I,
  input  wire logic                      LF_CLK_FAIL_I,
  input  wire logic                      DCM_I,
  // engines
  input  wire eng_in_s [NE-1:0]          ENG_I,
  output eng_out_s     [NE-1:0]          ENG_O,
  // analog side and event
  output logic      [N_ACOMP*ATHR_W-1:0] ACOMP_THR_O,
  output logic                           FAULT_EVENT_O
);
  logic [31:0]          ctrl_q;
  logic [31:0]          ext_q;
  logic [31:0]          engcfg_q;
  logic [31:0]          misc_q;
  logic [THR_W:0]       dcomp_q  [N_DCOMP];
  logic [ATHR_W-1:0]    athr_q   [N_ACOMP];
  logic [31:0]          maxcnt_q [NE];
  logic [N_SRC-1:0]     mask_q   [NE*N_MOD];
  logic [N_SRC-1:0]     src_q;
  logic [N_SRC-1:0]     src_d;
  logic [NE*N_MOD-1:0]  flag;
  logic [CNT_W-1:0]     cnt      [NE*N_MOD];
  logic [NE-1:0]        trunc_q;
  logic [NE-1:0]        eng_en;
  logic                 fault_en;
  logic [31:0]          rdata_q;
  logic [31:0]          rd_d;
  eng_out_s [NE-1:0]    out_q;
  logic                 event_q;

  assign fault_en = ctrl_q[F_FEN];
  assign eng_en   = ctrl_q[F_ENGEN +: NE];

  // register writes
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      ctrl_q   <= RST_ZERO;
      ext_q    <= RST_ZERO;
      engcfg_q <= RST_ZERO;
      misc_q   <= RST_ZERO;
    end else if (WR_I) begin
      case (ADDR_I)
        A_CTRL:   ctrl_q   <= WDATA_I;
        A_EXT:    ext_q    <= WDATA_I;
        A_ENGCFG: engcfg_q <= WDATA_I;
        A_MISC:   misc_q   <= WDATA_I;
        default:  ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    for (int i = 0; i < N_DCOMP; i++) begin
      if (SYS_RST_I) begin
        dcomp_q[i] <= '0;
      end else if (WR_I && ADDR_I == A_DCOMP + 8'(i)) begin
        dcomp_q[i] <= {WDATA_I[F_DCEN], WDATA_I[THR_W-1:0]};
      end
    end
    for (int i = 0; i < N_ACOMP; i++) begin
      if (SYS_RST_I) begin
        athr_q[i] <= '0;
      end else if (WR_I && ADDR_I == A_ATHR + 8'(i)) begin
        athr_q[i] <= WDATA_I[ATHR_W-1:0];
      end
    end
    for (int i = 0; i < NE; i++) begin
      if (SYS_RST_I) begin
        maxcnt_q[i] <= RST_ZERO;
      end else if (WR_I && ADDR_I == A_MAXCNT + 8'(i)) begin
        maxcnt_q[i] <= WDATA_I;
      end
    end
    for (int i = 0; i < NE*N_MOD; i++) begin
      if (SYS_RST_I) begin
        mask_q[i] <= '0;
      end else if (WR_I && ADDR_I == A_MASK + 8'(i)) begin
        mask_q[i] <= WDATA_I[N_SRC-1:0];
      end
    end
  end

  // analog thresholds out
  always_comb begin
    for (int i = 0; i < N_ACOMP; i++) begin
      ACOMP_THR_O[i*ATHR_W +: ATHR_W] = athr_q[i];
    end
  end

  // source vector
  always_comb begin
    src_d = '0;
    for (int i = 0; i < N_DCOMP; i++) begin
      src_d[S_DCOMP+i] = dcomp_q[i][THR_W] &&
        (DCOMP_VAL_I[i*THR_W +: THR_W] > dcomp_q[i][THR_W-1:0]);
    end
    for (int i = 0; i < N_ACOMP; i++) begin
      src_d[S_ACOMP+i] = ACOMP_I[i] & misc_q[F_ACEN+i];
    end
    for (int i = 0; i < N_EXT; i++) begin
      src_d[S_EXT+i] = ext_q[i] & (EXT_FAULT_I[i] ^ ext_q[F_EXTPOL+i]);
    end
    for (int e = 0; e < NE; e++) begin
      src_d[S_ENG+e] = |(engcfg_q[e*N_EFLT +: N_EFLT] &
        {ENG_I[e].diode_emulation_flag, ENG_I[e].ext_b, ENG_I[e].ext_a,
         ENG_I[e].ov, ENG_I[e].cur_lim});
    end
    src_d[S_HF]  = HF_CLK_FAIL_I & misc_q[F_HFEN];
    src_d[S_LF]  = LF_CLK_FAIL_I & misc_q[F_LFEN];
    src_d[S_DCM] = DCM_I & misc_q[F_DCMEN];
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      src_q <= '0;
    end else begin
      src_q <= src_d;
    end
  end

  // shared fault event
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      event_q <= 1'b0;
    end else begin
      event_q <= |src_d[S_ACOMP +: N_ACOMP] |
                 |(src_d[S_ENG +: NE] & {NE{1'b1}});
    end
  end
  assign FAULT_EVENT_O = event_q;

  // four modules per engine, the CBC one also taking pcm
  for (genvar e = 0; e < NE; e++) begin : g_eng
    for (genvar m = 0; m < N_MOD; m++) begin : g_mod
      logic fin;
      // masked or of selected sources
      if (m == M_CBC) begin : g_cbc
        assign fin = (|(src_q & mask_q[e*N_MOD+m])) | ENG_I[e].pcm;
      end else begin : g_oth
        assign fin = |(src_q & mask_q[e*N_MOD+m]);
      end
      fault_cell u_cell (
        .clk_i       (CLK_SYS_I),
        .rst_i       (SYS_RST_I),
        .eng_en_i    (eng_en[e]),
        .fault_en_i  (fault_en),
        .cyc_start_i (ENG_I[e].cyc_start),
        .fault_i     (fin),
        .max_cnt_i   (maxcnt_q[e][m*8 +: CNT_W]),
        .flag_o      (flag[e*N_MOD+m]),
        .cnt_o       (cnt[e*N_MOD+m])
      );
    end
  end

  // cycle-by-cycle block, one per engine
  always_ff @(posedge CLK_SYS_I) begin
    for (int e = 0; e < NE; e++) begin
      if (SYS_RST_I || !eng_en[e]) begin
        trunc_q[e] <= 1'b0;
      end else begin
        trunc_q[e] <= (ENG_I[e].pcm & fault_en) |
                      (trunc_q[e] & ~ENG_I[e].cyc_start);
      end
    end
  end

  // output gating
  always_ff @(posedge CLK_SYS_I) begin
    for (int e = 0; e < NE; e++) begin
      if (SYS_RST_I) begin
        out_q[e] <= '0;
      end else begin
        out_q[e].pwm_a <= ENG_I[e].pwm_a & ~trunc_q[e] &
          ~(flag[e*N_MOD+M_CBC] | flag[e*N_MOD+M_AB] | flag[e*N_MOD+M_A]);
        out_q[e].pwm_b <= ENG_I[e].pwm_b &
          ~(trunc_q[e] & ctrl_q[F_BMATCH+e]) &
          ~(flag[e*N_MOD+M_CBC] | flag[e*N_MOD+M_AB] | flag[e*N_MOD+M_B]);
      end
    end
  end
  assign ENG_O = out_q;

  // register reads
  always_comb begin
    rd_d = RST_ZERO;
    case (ADDR_I)
      A_CTRL:   rd_d = ctrl_q;
      A_EXT:    rd_d = ext_q;
      A_ENGCFG: rd_d = engcfg_q;
      A_MISC:   rd_d = misc_q;
      A_STATUS: rd_d[NE*N_MOD-1:0] = flag;
      A_SRC:    rd_d[N_SRC-1:0] = src_q;
      default: begin
        for (int i = 0; i < N_DCOMP; i++) begin
          if (ADDR_I == A_DCOMP + 8'(i)) begin
            rd_d[THR_W-1:0] = dcomp_q[i][THR_W-1:0];
            rd_d[F_DCEN]    = dcomp_q[i][THR_W];
          end
        end
        for (int i = 0; i < N_ACOMP; i++) begin
          if (ADDR_I == A_ATHR + 8'(i)) begin
            rd_d[ATHR_W-1:0] = athr_q[i];
          end
        end
        for (int i = 0; i < NE; i++) begin
          if (ADDR_I == A_MAXCNT + 8'(i)) begin
            rd_d = maxcnt_q[i];
          end
        end
        for (int i = 0; i < NE*N_MOD; i++) begin
          if (ADDR_I == A_MASK + 8'(i)) begin
            rd_d[N_SRC-1:0] = mask_q[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      rdata_q <= RST_ZERO;
    end else begin
      rdata_q <= RD_I ? rd_d : RST_ZERO;
    end
  end
  assign RDATA_O = rdata_q;

  // checks on engine 0, plus one cycle-by-cycle check on engine 1
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_boundary;
    ENG_I[0].cyc_start;
  endsequence

  chk_flag_clear_all: assert property (!eng_en[0] |=> flag[3:0] == 4'h0)
    else $error("flags not cleared by engine disable");
  chk_flag_sticky: assert property (flag[0] && eng_en[0] |=> flag[0])
    else $error("flag dropped while engine enabled");
  chk_global_gate: assert property (!fault_en && !trunc_q[0] |=> !$rose(flag[1]))
    else $error("flag set with global fault enable low");
  chk_both_held: assert property (flag[M_AB] |=> !ENG_O[0].pwm_a && !ENG_O[0].pwm_b)
    else $error("both outputs not held by fault");
  chk_a_held: assert property (flag[M_A] |=> !ENG_O[0].pwm_a)
    else $error("output A not held by fault");
  chk_b_held: assert property (flag[M_B] |=> !ENG_O[0].pwm_b)
    else $error("output B not held by fault");
  chk_count_step: assert property ((s_boundary and eng_en[0]) |=>
      (cnt[1] == RST_CNT) || (cnt[1] == $past(cnt[1]) + 4'h1) ||
      (cnt[1] == $past(cnt[1])))
    else $error("counter moved by more than one per cycle");
  chk_count_hold: assert property (!ENG_I[0].cyc_start && eng_en[0] |=> $stable(cnt[1]))
    else $error("counter changed inside a cycle");
  chk_flag_limit: assert property ($rose(flag[1]) |->
      $past(ENG_I[0].cyc_start) && ($past(cnt[1]) + 5'h01 > {1'b0, maxcnt_q[0][11:8]}))
    else $error("flag set before limit exceeded");
  chk_trunc_a: assert property (trunc_q[1] |=> !ENG_O[1].pwm_a)
    else $error("output A not cut by cycle-by-cycle block");
endmodule : pwm_fault_response_mux

`default_nettype wire

// ===== verif/pwm_engine_model.sv
// Purpose: stand-in for the pwm engines on the far side of the fault block
// Assumes: all engines share one switching period of PERIOD clocks
// Notes:   pwm levels held high so any gating shows at the block outputs
`timescale 1ns/100ps
`default_nettype none

module pwm_engine_model
  import fault_mux_pkg::*;
#(
  parameter int unsigned NE     = N_ENG,
  parameter int unsigned PERIOD = 8
)
(
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // fault requests from the bench
  input  wire logic [NE-1:0]          pcm_i,
  input  wire logic [NE*N_EFLT-1:0]   eflt_i,
  // engine side
  output eng_in_s   [NE-1:0]          eng_o
);
  logic [7:0] cnt_q;

  // switching period counter
  always_ff @(posedge clk_i) begin
    if (rst_i || cnt_q == 8'(PERIOD - 1)) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // one-cycle start pulse, levels for the rest
  always_comb begin
    for (int e = 0; e < NE; e++) begin
      eng_o[e].cyc_start = !rst_i && (cnt_q == 8'(PERIOD - 1));
      eng_o[e].pwm_a = !rst_i;
      eng_o[e].pwm_b = !rst_i;
      eng_o[e].pcm = pcm_i[e];
      {eng_o[e].cur_lim, eng_o[e].ov, eng_o[e].ext_a, eng_o[e].ext_b,
       eng_o[e].diode_emulation_flag} = eflt_i[e*N_EFLT +: N_EFLT];
    end
  end
endmodule : pwm_engine_model

`default_nettype wire

// ===== verif/test_pwm_fault_response_mux.sv
// Purpose: self-checking bench for the fault routing block
// Assumes: register reads answer one cycle after the strobe
// Notes:   reads queue their expected word, a monitor compares
`timescale 1ns/100ps
`default_nettype none

module test_pwm_fault_response_mux;
  import fault_mux_pkg::*;
  localparam int unsigned P = 8;
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic [7:0]                addr = 8'h00;
  logic [31:0]               wdata = 32'h0;
  logic                      wr = 1'b0;
  logic                      rd = 1'b0;
  logic [31:0]               rdata;
  logic [N_DCOMP*THR_W-1:0]  dval = '0;
  logic [N_ACOMP-1:0]        acomp = '0;
  logic [N_EXT-1:0]          ext = '0;
  logic                      hf = 1'b0;
  logic                      lf = 1'b0;
  logic                      dcm = 1'b0;
  logic [N_ENG-1:0]          pcm = '0;
  logic [N_ENG*N_EFLT-1:0]   eflt = '0;
  eng_in_s  [N_ENG-1:0]      eng_in;
  eng_out_s [N_ENG-1:0]      eng_out;
  logic [N_ACOMP*ATHR_W-1:0] athr;
  logic                      fevt;
  logic                      rd_seen = 1'b0;
  logic [31:0]               exp_q[$];
  logic [11:0]               thr[N_DCOMP];
  logic [3:0]                pol;
  logic [6:0]                at;
  int                        sel;
  int                        bad_count = 0;
  int                        tests_run = 0;

  always #20 clk = ~clk;

  pwm_engine_model #(.NE(N_ENG), .PERIOD(P)) eng_u (
    .clk_i(clk), .rst_i(rst), .pcm_i(pcm), .eflt_i(eflt), .eng_o(eng_in));

  pwm_fault_response_mux #(.NE(N_ENG)) dut_u (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .DCOMP_VAL_I(dval), .ACOMP_I(acomp), .EXT_FAULT_I(ext),
    .HF_CLK_FAIL_I(hf), .LF_CLK_FAIL_I(lf), .DCM_I(dcm), .ENG_I(eng_in), .ENG_O(eng_out),
    .ACOMP_THR_O(athr), .FAULT_EVENT_O(fevt));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : rd_reg

  task automatic sync();
    do @(posedge clk); while (eng_in[0].cyc_start !== 1'b1);
  endtask : sync

  // n switching cycles of pulsed or absent fault on analog comparator 0
  task automatic span(input int n, input logic on);
    sync();
    for (int i = 0; i < n * P - 2; i++) begin
      acomp[0] <= on && (i % 3 != 2);
      @(posedge clk);
    end
    acomp[0] <= 1'b0;
  endtask : span

  task automatic set_src(input int s, input logic v);
    if (s < S_ACOMP) dval[s*THR_W +: THR_W] <= v ? thr[s] + 12'h001 : thr[s];
    else if (s < S_EXT) acomp[s-S_ACOMP] <= v;
    else if (s < S_ENG) ext[s-S_EXT] <= v ^ pol[s-S_EXT];
    else if (s < S_HF) eflt[(s-S_ENG)*N_EFLT+sel] <= v;
    else if (s == S_HF) hf <= v;
    else if (s == S_LF) lf <= v;
    else dcm <= v;
  endtask : set_src

  task automatic reenable(input logic [31:0] c);
    wr_reg(A_CTRL, 32'h0000_0001);
    rd_reg(A_STATUS, RST_ZERO);
    wr_reg(A_CTRL, c);
  endtask : reenable

  // read data monitor
  always @(posedge clk) begin
    rd_seen <= rd;
    if (rd_seen) chk("rdata", exp_q.pop_front(), rdata);
  end

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  initial begin
    sel = $urandom(32'h605E76A1);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    pol = 4'($urandom);
    ext <= pol;
    rd_reg(A_CTRL, RST_ZERO);
    wr_reg(8'h30, 32'hFFFF_FFFF);
    rd_reg(8'h30, RST_ZERO);
    wr_reg(A_STATUS, 32'hFFFF_FFFF);
    rd_reg(A_STATUS, RST_ZERO);
    for (int k = 0; k < N_DCOMP; k++) begin
      thr[k] = 12'($urandom % 32'hFFF);
      dval[k*THR_W +: THR_W] <= thr[k];
      wr_reg(A_DCOMP + 8'(k), {15'h0, 1'b1, 4'h0, thr[k]});
      rd_reg(A_DCOMP + 8'(k), {15'h0, 1'b1, 4'h0, thr[k]});
    end
    for (int k = 0; k < N_ACOMP; k++) begin
      at = 7'($urandom);
      wr_reg(A_ATHR + 8'(k), {25'h0, at});
      chk("athr", {25'h0, at}, {25'h0, athr[k*ATHR_W +: ATHR_W]});
    end
    wr_reg(A_EXT, {24'h0, pol, 4'hF});
    wr_reg(A_ENGCFG, 32'h000F_FFFF);
    wr_reg(A_MISC, 32'h0000_03FF);
    wr_reg(A_CTRL, 32'h0000_00F1);
    for (int s = 0; s < N_SRC; s++) begin
      for (int e = 0; e < N_ENG; e++)
        wr_reg(A_MASK + 8'(e*4+M_AB), (32'h1 << s) | (32'h1 << ((s + 7) % N_SRC)));
      sel = $urandom % N_EFLT;
      set_src(s, 1'b1);
      wait_span(3);
      rd_reg(A_SRC, 32'h1 << s);
      rd_reg(A_STATUS, 32'h0000_2222);
      chk("event", {31'h0, (s >= S_ACOMP && s < S_EXT) || (s >= S_ENG && s < S_HF)},
          {31'h0, fevt});
      chk("eng_out", 32'h0, {24'h0, eng_out});
      set_src(s, 1'b0);
      wait_span(2);
      reenable(32'h0000_00F1);
    end
    for (int e = 0; e < N_ENG; e++) wr_reg(A_MASK + 8'(e*4+M_AB), RST_ZERO);
    wr_reg(A_CTRL, 32'h0000_00F0);
    set_src(S_ACOMP, 1'b1);
    wait_span(3);
    rd_reg(A_STATUS, RST_ZERO);
    chk("eng_out", 32'h0000_00FF, {24'h0, eng_out});
    set_src(S_ACOMP, 1'b0);
    wait_span(2);
    wr_reg(A_CTRL, 32'h0000_00F1);
    for (int m = 0; m < N_MOD; m++) begin
      wr_reg(A_MASK + 8'(m), 32'h1 << S_ACOMP);
      set_src(S_ACOMP, 1'b1);
      wait_span(3);
      rd_reg(A_STATUS, 32'h1 << m);
      chk("eng0_out", {30'h0, m == M_B, m == M_A}, {30'h0, eng_out[0]});
      chk("eng_rest", 32'h3F, {26'h0, eng_out[3:1]});
      wr_reg(A_MASK + 8'(m), RST_ZERO);
      set_src(S_ACOMP, 1'b0);
      wait_span(2);
      reenable(32'h0000_00F1);
    end
    sync();
    pcm[1] <= 1'b1;
    repeat (3) @(posedge clk);
    chk("trunc", 32'h1, {30'h0, eng_out[1]});
    wait_span(2);
    rd_reg(A_STATUS, 32'h0000_0010);
    pcm[1] <= 1'b0;
    reenable(32'h0000_02F1);
    sync();
    pcm[1] <= 1'b1;
    repeat (3) @(posedge clk);
    chk("trunc_b", 32'h0, {30'h0, eng_out[1]});
    pcm[1] <= 1'b0;
    reenable(32'h0000_00F1);
    wr_reg(A_MAXCNT, 32'h0000_0200);
    wr_reg(A_MASK + 8'(M_AB), 32'h1 << S_ACOMP);
    span(1, 1'b0);
    span(2, 1'b1);
    span(1, 1'b0);
    rd_reg(A_STATUS, RST_ZERO);
    span(2, 1'b1);
    span(1, 1'b0);
    rd_reg(A_STATUS, RST_ZERO);
    span(3, 1'b1);
    span(2, 1'b0);
    rd_reg(A_STATUS, 32'h0000_0002);
    for (int m = 0; m < N_MOD; m++) wr_reg(A_MASK + 8'(m), 32'h1 << S_ACOMP);
    wr_reg(A_MASK + 8'(4+M_AB), 32'h1 << S_ACOMP);
    wr_reg(A_MAXCNT, RST_ZERO);
    set_src(S_ACOMP, 1'b1);
    wait_span(3);
    rd_reg(A_STATUS, 32'h0000_002F);
    wr_reg(A_CTRL, 32'h0000_00E1);
    rd_reg(A_STATUS, 32'h0000_0020);
    set_src(S_ACOMP, 1'b0);
    repeat (4) @(posedge clk);
    stop_test();
  end

  task automatic wait_span(input int n);
    repeat (n * P) @(posedge clk);
  endtask : wait_span
endmodule : test_pwm_fault_response_mux

`default_nettype wire
